// File: hdl/hsc_pkg.sv
/*
  Shared constants and types for the preset-table pulse counter and the
  step sequencer bank.
  Assumes a single 25 MHz core clock and an active-low asynchronous reset.
*/
package hsc_pkg;

  // ----------------------------------------------------------------
  // clock and rates
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 25_000_000;
  localparam int unsigned PULSE_RATE_MAX_HZ = 2000;
  // core cycles between two pulses at the top rate
  localparam int unsigned PULSE_GAP_CYCLES = CORE_CLK_HZ / PULSE_RATE_MAX_HZ;

  // ----------------------------------------------------------------
  // counter identity and range
  // ----------------------------------------------------------------
  localparam logic [9:0] HSC_REF_ID = 10'h0270;
  localparam logic [13:0] COUNT_MAX = 14'h270F;
  localparam logic [13:0] COUNT_RST = 14'h0000;
  localparam logic [13:0] SLOT_EMPTY = 14'h3FFF;

  // ----------------------------------------------------------------
  // preset table
  // ----------------------------------------------------------------
  localparam int TABLE_DEPTH = 20;
  localparam logic [4:0] TABLE_FULL_USED = 5'h14;
  localparam logic [4:0] TABLE_USED_RST = 5'h00;

  // status codes shown to the programmer; values are arbitrary
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_TABLE_FULL = 8'h13;
  localparam logic [7:0] ERR_PRESET_RANGE = 8'h14;

  // ----------------------------------------------------------------
  // program addressing, one word per entry
  // ----------------------------------------------------------------
  localparam logic [10:0] ADDR_START = 11'h000;

  // ----------------------------------------------------------------
  // sequencers
  // ----------------------------------------------------------------
  localparam int SEQ_COUNT = 20;
  localparam logic [9:0] SEQ_STEP_HOME = 10'h000;
  localparam logic [9:0] SEQ_STEP_LIMIT = 10'h03E7;

  typedef logic [13:0] count_t;
  typedef logic [10:0] addr_t;
  typedef logic [9:0] step_t;
  typedef enum logic [1:0] {MODE_PROG, MODE_SCAN, MODE_INTR} mode_e;

endpackage : hsc_pkg

// File: hdl/seq_bank.sv
/*
  Bank of step sequencers, each driven by its own count and clear
  conditions from the logic scan.
  Assumes the conditions come from logic on CORE_CLK, so no synchronising.
*/
`timescale 1ns/100ps
`default_nettype none

module seq_bank (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [hsc_pkg::SEQ_COUNT-1:0] step_cond,
  input wire logic [hsc_pkg::SEQ_COUNT-1:0] clear_cond,
  input wire logic pre_we,
  input wire logic [4:0] pre_idx,
  input wire hsc_pkg::step_t pre_val,
  input wire logic [4:0] sel,
  input wire hsc_pkg::step_t cmp,
  output hsc_pkg::step_t pos,
  output logic match
);
  import hsc_pkg::*;

  step_t pos_ff [SEQ_COUNT];
  step_t pre_ff [SEQ_COUNT];
  logic [SEQ_COUNT-1:0] prev_ff;

  // ----------------------------------------------------------------
  // per-sequencer stepping
  // ----------------------------------------------------------------
  // a preset of zero or above the limit means the full range
  function automatic step_t limit_of(input step_t p);
    limit_of = (p == SEQ_STEP_HOME || p > SEQ_STEP_LIMIT) ? SEQ_STEP_LIMIT : p;
  endfunction : limit_of

  genvar g;
  generate
    for (g = 0; g < SEQ_COUNT; g++) begin : g_seq
      wire logic rise = step_cond[g] & ~prev_ff[g];
      wire logic at_end = (pos_ff[g] >= limit_of(pre_ff[g]));
      wire logic pre_hit = pre_we && (pre_idx == 5'(g));
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pos_ff[g] <= SEQ_STEP_HOME;
          pre_ff[g] <= SEQ_STEP_LIMIT;
          prev_ff[g] <= 1'b0;
        end else begin
          prev_ff[g] <= step_cond[g];
          if (pre_hit) begin
            pre_ff[g] <= pre_val;
          end
          if (clear_cond[g]) begin
            pos_ff[g] <= SEQ_STEP_HOME;
          end else if (rise && !at_end) begin
            pos_ff[g] <= pos_ff[g] + 10'h001;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // position read and compare contact
  // ----------------------------------------------------------------
  wire logic sel_ok = (sel < 5'(SEQ_COUNT));
  wire step_t sel_pos = sel_ok ? pos_ff[sel] : SEQ_STEP_HOME;

  assign pos = sel_pos;
  assign match = sel_ok && (sel_pos == cmp);

endmodule : seq_bank

`default_nettype wire

// File: hdl/hsc_core.sv
/*
  High speed pulse counter with a sorted preset table that interrupts the
  logic scan on a match, plus the step sequencer bank.
  Assumes a scan engine on CORE_CLK that reports each executed rung, and
  field pins that are asynchronous to CORE_CLK.
*/
// Notes on behaviour
// - hardware clear pin clears the count, as does the programmed clear condition.
// - counter exists only once defined under its one fixed reference number.
// - presets loaded before run are kept sorted ascending in a table.
// - on a rung in the scan, a count matching any entry restarts the scan at address zero, once per count value.
// - outputs of the counter program commit at the definition rung in an interrupt pass.
// - after the definition rung in an interrupt pass, resume at the interrupted rung.
// - the preset table holds at most twenty entries.
// - a preset beyond the table limit is rejected with a distinct error code.
// - pulses up to two thousand per second are counted.
// - every program entry, presets included, is one word of program memory.
// - twenty sequencers, each up to one thousand steps.
// - a sequencer goes home on clear and steps up once per count.
// - a sequencer's step reads at any time as its stored count.
// - a counter preset limits its sequencer below the full step count.
// - a compare contact passes power only while the count equals its value.
// - an active clear forces the sequencer home whatever its position.
// - the pulse pin counts only while the count-enable condition is true.
// - one count per off-to-on transition, none while the input stays on.
// - presets and the count reach up to 9999.
`timescale 1ns/100ps
`default_nettype none

module hsc_core (
  input wire logic CORE_CLK,
  input wire logic NRST,
  // field pins
  input wire logic PULSE_INPUT_TERMINAL,
  input wire logic HW_CLEAR_TERMINAL,
  // rung conditions solved by the scan
  input wire logic COUNT_ENABLE,
  input wire logic CLEAR_COND,
  // program load
  input wire logic DEF_VALID,
  input wire logic [9:0] DEF_REF,
  input wire logic PRESET_VALID,
  input wire hsc_pkg::count_t PRESET_VALUE,
  input wire logic TABLE_CLEAR,
  input wire logic RUN_REQ,
  input wire logic STOP_REQ,
  // scan progress
  input wire logic RUNG_STEP,
  input wire hsc_pkg::addr_t RUNG_ADDR,
  input wire logic RUNG_IS_DEF,
  output logic RESTART,
  output logic RESUME,
  output hsc_pkg::addr_t RESUME_ADDR,
  output logic OUT_COMMIT,
  output logic INTR_PASS,
  output logic RUN_MODE,
  // status
  output hsc_pkg::count_t HSC_COUNT,
  output logic HSC_DEFINED,
  output logic PRESET_REJECT,
  output logic [7:0] ERR_CODE,
  output logic [4:0] TABLE_USED,
  // sequencers
  input wire logic [hsc_pkg::SEQ_COUNT-1:0] SEQ_STEP_COND,
  input wire logic [hsc_pkg::SEQ_COUNT-1:0] SEQ_CLEAR_COND,
  input wire logic SEQ_PRE_WE,
  input wire logic [4:0] SEQ_PRE_IDX,
  input wire hsc_pkg::step_t SEQ_PRE_VAL,
  input wire logic [4:0] SEQ_SEL,
  input wire hsc_pkg::step_t SEQ_CMP,
  output hsc_pkg::step_t SEQ_POS,
  output logic SEQ_MATCH
);
  import hsc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic pulse_meta_ff;
  logic pulse_sync_ff;
  logic pulse_prev_ff;
  logic clr_meta_ff;
  logic clr_sync_ff;

  // pulse_prev_ff is history for the edge detector only; it never
  // feeds anything but the rise decode below
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      pulse_meta_ff <= 1'b0;
      pulse_sync_ff <= 1'b0;
      pulse_prev_ff <= 1'b0;
    end else begin
      pulse_meta_ff <= PULSE_INPUT_TERMINAL;
      pulse_sync_ff <= pulse_meta_ff;
      pulse_prev_ff <= pulse_sync_ff;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      clr_meta_ff <= 1'b0;
      clr_sync_ff <= 1'b0;
    end else begin
      clr_meta_ff <= HW_CLEAR_TERMINAL;
      clr_sync_ff <= clr_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mode_e mode_ff;
  mode_e nxt_mode;
  count_t count_ff;
  count_t nxt_count;
  logic defined_ff;
  count_t table_ff [TABLE_DEPTH];
  logic [4:0] used_ff;
  logic [7:0] err_ff;
  logic reject_ff;
  addr_t resume_addr_ff;
  // count value that already caused a pass
  count_t served_ff;
  logic served_vld_ff;
  logic restart_ff;
  logic resume_ff;
  logic commit_ff;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  // a 2 kHz stream leaves thousands of core cycles between edges, so a
  // plain edge detector on the synchronised pin keeps up with margin
  wire logic pulse_rise = pulse_sync_ff & ~pulse_prev_ff;
  wire logic count_ok = defined_ff && COUNT_ENABLE;
  wire logic clear_now = clr_sync_ff || CLEAR_COND;
  wire logic at_top = (count_ff >= COUNT_MAX);

  // saturate rather than wrap, so a wrap never walks the low presets again
  always_comb begin
    nxt_count = count_ff;
    if (clear_now) begin
      nxt_count = COUNT_RST;
    end else if (pulse_rise && count_ok && !at_top) begin
      nxt_count = count_ff + 14'h0001;
    end
  end

  // ----------------------------------------------------------------
  // preset table, kept sorted on every insert
  // ----------------------------------------------------------------
  wire logic in_prog = (mode_ff == MODE_PROG);
  wire logic preset_range_bad = (PRESET_VALUE > COUNT_MAX);
  wire logic table_full = (used_ff >= TABLE_FULL_USED);
  wire logic preset_take = PRESET_VALID && in_prog && !table_full && !preset_range_bad;
  wire logic preset_refuse = PRESET_VALID && in_prog && (table_full || preset_range_bad);
  // a wipe only acts in program mode, like DEF_VALID and PRESET_VALID
  wire logic table_wipe = TABLE_CLEAR && in_prog;

  // empty slots hold a value above any legal preset, so the insertion
  // network needs no separate occupancy test
  count_t ins_tbl [TABLE_DEPTH];
  logic [TABLE_DEPTH-1:0] hit_vec;

  genvar g;
  generate
    for (g = 0; g < TABLE_DEPTH; g++) begin : g_tbl
      if (g == 0) begin : g_first
        assign ins_tbl[g] = (table_ff[g] <= PRESET_VALUE) ? table_ff[g] : PRESET_VALUE;
      end else begin : g_rest
        assign ins_tbl[g] = (table_ff[g] <= PRESET_VALUE) ? table_ff[g] :
                            (table_ff[g-1] <= PRESET_VALUE) ? PRESET_VALUE : table_ff[g-1];
      end
      // slots past the entry count never match, whatever they hold
      assign hit_vec[g] = (5'(g) < used_ff) && (table_ff[g] == count_ff);
    end
  endgenerate

  // a wipe outranks an insert in the same cycle
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < TABLE_DEPTH; i++) begin
        table_ff[i] <= SLOT_EMPTY;
      end
    end else if (table_wipe) begin
      for (int i = 0; i < TABLE_DEPTH; i++) begin
        table_ff[i] <= SLOT_EMPTY;
      end
    end else if (preset_take) begin
      for (int i = 0; i < TABLE_DEPTH; i++) begin
        table_ff[i] <= ins_tbl[i];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      used_ff <= TABLE_USED_RST;
      err_ff <= ERR_NONE;
      reject_ff <= 1'b0;
      defined_ff <= 1'b0;
    end else begin
      reject_ff <= preset_refuse;
      if (table_wipe) begin
        used_ff <= TABLE_USED_RST;
      end else if (preset_take) begin
        used_ff <= used_ff + 5'h01;
      end
      if (preset_refuse) begin
        err_ff <= table_full ? ERR_TABLE_FULL : ERR_PRESET_RANGE;
      end else if (table_wipe) begin
        err_ff <= ERR_NONE;
      end
      if (DEF_VALID && in_prog && DEF_REF == HSC_REF_ID) begin
        defined_ff <= 1'b1;
      end else if (table_wipe) begin
        defined_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // scan interrupt sequencing
  // ----------------------------------------------------------------
  // a match is served once per count value; the scan keeps re-reading the
  // same count until the next pulse, and restarting each time would stall it
  wire logic table_hit = defined_ff && (|hit_vec);
  wire logic already_served = served_vld_ff && (served_ff == count_ff);
  wire logic start_intr = (mode_ff == MODE_SCAN) && RUNG_STEP && table_hit && !already_served;
  wire logic end_intr = (mode_ff == MODE_INTR) && RUNG_STEP && RUNG_IS_DEF;
  // a stop request aborts the pass without any jump pulse
  wire logic intr_take = start_intr && !STOP_REQ;
  wire logic intr_done = end_intr && !STOP_REQ;

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      MODE_PROG: begin
        if (RUN_REQ) begin
          nxt_mode = MODE_SCAN;
        end
      end
      MODE_SCAN: begin
        if (STOP_REQ) begin
          nxt_mode = MODE_PROG;
        end else if (start_intr) begin
          nxt_mode = MODE_INTR;
        end
      end
      MODE_INTR: begin
        if (STOP_REQ) begin
          nxt_mode = MODE_PROG;
        end else if (end_intr) begin
          nxt_mode = MODE_SCAN;
        end
      end
      default: begin
        nxt_mode = MODE_PROG;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      mode_ff <= MODE_PROG;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      count_ff <= COUNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      restart_ff <= 1'b0;
      resume_ff <= 1'b0;
      commit_ff <= 1'b0;
    end else begin
      restart_ff <= intr_take;
      commit_ff <= intr_done;
      resume_ff <= intr_done;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      resume_addr_ff <= ADDR_START;
      served_ff <= COUNT_RST;
      served_vld_ff <= 1'b0;
    end else if (intr_take) begin
      resume_addr_ff <= RUNG_ADDR;
      served_ff <= count_ff;
      served_vld_ff <= 1'b1;
    end else if (in_prog) begin
      served_vld_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer bank
  // ----------------------------------------------------------------
  seq_bank u_seq_bank (
    .clk(CORE_CLK),
    .nrst(NRST),
    .step_cond(SEQ_STEP_COND),
    .clear_cond(SEQ_CLEAR_COND),
    .pre_we(SEQ_PRE_WE),
    .pre_idx(SEQ_PRE_IDX),
    .pre_val(SEQ_PRE_VAL),
    .sel(SEQ_SEL),
    .cmp(SEQ_CMP),
    .pos(SEQ_POS),
    .match(SEQ_MATCH)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // jump pulses come straight from flops so the scan engine sees clean single cycles
  assign RESTART = restart_ff;
  assign RESUME = resume_ff;
  assign RESUME_ADDR = resume_addr_ff;
  assign OUT_COMMIT = commit_ff;
  assign INTR_PASS = (mode_ff == MODE_INTR);
  assign RUN_MODE = (mode_ff != MODE_PROG);
  assign HSC_COUNT = count_ff;
  assign HSC_DEFINED = defined_ff;
  assign PRESET_REJECT = reject_ff;
  assign ERR_CODE = err_ff;
  assign TABLE_USED = used_ff;

endmodule : hsc_core

`default_nettype wire

// File: dv/hsc_core_monitor.sv
/*
  Concurrent checks on the pulse counter top ports.
  Assumes one CORE_CLK domain and NRST low as reset.
*/
`timescale 1ns/100ps
`default_nettype none

module hsc_core_monitor
  import hsc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic HW_CLEAR_TERMINAL,
  input wire logic COUNT_ENABLE,
  input wire logic CLEAR_COND,
  input wire logic PRESET_VALID,
  input wire logic STOP_REQ,
  input wire logic RUNG_STEP,
  input wire hsc_pkg::addr_t RUNG_ADDR,
  input wire logic RUNG_IS_DEF,
  input wire logic RESTART,
  input wire logic RESUME,
  input wire hsc_pkg::addr_t RESUME_ADDR,
  input wire logic OUT_COMMIT,
  input wire logic INTR_PASS,
  input wire logic RUN_MODE,
  input wire hsc_pkg::count_t HSC_COUNT,
  input wire logic HSC_DEFINED,
  input wire logic PRESET_REJECT,
  input wire logic [4:0] TABLE_USED,
  input wire logic [hsc_pkg::SEQ_COUNT-1:0] SEQ_CLEAR_COND,
  input wire logic [4:0] SEQ_SEL,
  input wire hsc_pkg::step_t SEQ_CMP,
  input wire hsc_pkg::step_t SEQ_POS,
  input wire logic SEQ_MATCH
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence def_rung_s;
    RUNG_STEP && RUNG_IS_DEF && INTR_PASS && RUN_MODE && !STOP_REQ;
  endsequence
  // pin passes two sync flops first, hence the long hold
  sequence hw_clr_s;
    HW_CLEAR_TERMINAL [*5];
  endsequence
  sequence sel_clr_s;
    (SEQ_SEL < 5'h14 && SEQ_CLEAR_COND[SEQ_SEL]) ##1 $stable(SEQ_SEL);
  endsequence

  // ----------------------------------------
  // properties
  // ----------------------------------------
  restart_cause_a: assert property (RESTART |-> $past(RUNG_STEP) && INTR_PASS)
    else $error("restart without a rung step");
  resume_addr_a: assert property (RESTART |-> RESUME_ADDR == $past(RUNG_ADDR))
    else $error("interrupted address not kept");
  def_resume_a: assert property (def_rung_s |=> RESUME && OUT_COMMIT && !INTR_PASS)
    else $error("definition rung did not resume");
  commit_pair_a: assert property (OUT_COMMIT == RESUME)
    else $error("commit and resume apart");
  clr_cond_a: assert property (CLEAR_COND |=> HSC_COUNT == COUNT_RST)
    else $error("clear condition left a count");
  hw_clear_a: assert property (hw_clr_s |=> HSC_COUNT == COUNT_RST)
    else $error("clear pin left a count");
  count_step_a: assert property (HSC_COUNT != $past(HSC_COUNT) |-> HSC_COUNT == COUNT_RST ||
    (HSC_COUNT == $past(HSC_COUNT) + 14'h0001 && $past(COUNT_ENABLE) && $past(HSC_DEFINED)))
    else $error("count moved wrongly");
  count_range_a: assert property (HSC_COUNT <= COUNT_MAX)
    else $error("count above range");
  table_limit_a: assert property (TABLE_USED <= TABLE_FULL_USED)
    else $error("table above limit");
  reject_keep_a: assert property (PRESET_REJECT |-> $past(PRESET_VALID) && $stable(TABLE_USED))
    else $error("reject changed the table");
  seq_match_a: assert property (SEQ_MATCH == (SEQ_SEL < 5'h14 && SEQ_POS == SEQ_CMP))
    else $error("compare contact wrong");
  seq_clear_a: assert property (sel_clr_s |-> SEQ_POS == SEQ_STEP_HOME)
    else $error("sequencer not home after clear");
endmodule : hsc_core_monitor

bind hsc_core hsc_core_monitor u_hsc_core_monitor (.*);

`default_nettype wire

// File: dv/field_src.sv
/*
  Field side model: pulse source and clear pin.
  Assumes requests arrive at the falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module field_src (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] n,
  input wire logic clr_req,
  output logic busy,
  output logic pin,
  output logic clr
);
  always @(negedge clk) clr <= clr_req;
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(negedge clk);
      if (start) begin
        busy = 1'b1;
        // six cycles per level keeps edges well apart
        repeat (n) begin
          pin = 1'b1;
          repeat (6) @(negedge clk);
          pin = 1'b0;
          repeat (6) @(negedge clk);
        end
        busy = 1'b0;
      end
    end
  end
endmodule : field_src

`default_nettype wire

// File: dv/hsc_core_tb.sv
/*
  Self-checking bench for the pulse counter and sequencers.
  Assumes hsc_pkg, hsc_core, field_src and the monitor are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module hsc_core_tb;
  import hsc_pkg::*;
  logic CORE_CLK = 1'b0;
  logic NRST = 1'b0;
  logic PULSE_INPUT_TERMINAL, HW_CLEAR_TERMINAL, COUNT_ENABLE, CLEAR_COND, DEF_VALID;
  logic PRESET_VALID, TABLE_CLEAR, RUN_REQ, STOP_REQ, RUNG_STEP, RUNG_IS_DEF;
  logic RESTART, RESUME, OUT_COMMIT, INTR_PASS, RUN_MODE, HSC_DEFINED, PRESET_REJECT;
  logic SEQ_PRE_WE, SEQ_MATCH, go, busy, clr_req;
  logic [9:0] DEF_REF;
  logic [7:0] ERR_CODE, n_go;
  logic [4:0] TABLE_USED, SEQ_PRE_IDX, SEQ_SEL;
  count_t PRESET_VALUE, HSC_COUNT;
  addr_t RUNG_ADDR, RESUME_ADDR;
  step_t SEQ_PRE_VAL, SEQ_CMP, SEQ_POS;
  logic [SEQ_COUNT-1:0] SEQ_STEP_COND, SEQ_CLEAR_COND;
  int n_errors = 0;
  int checked = 0;

  always #20 CORE_CLK = ~CORE_CLK;

  hsc_core u_hsc_core (.*);
  field_src u_field_src (.clk(CORE_CLK), .start(go), .n(n_go), .clr_req(clr_req),
    .busy(busy), .pin(PULSE_INPUT_TERMINAL), .clr(HW_CLEAR_TERMINAL));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task tick();
    @(negedge CORE_CLK);
  endtask : tick

  // one-cycle load strobe: 0 wipe, 1 define, 2 run, 3 sequencer preset, 4 stop
  task strobe(input int k);
    {TABLE_CLEAR, DEF_VALID, RUN_REQ, SEQ_PRE_WE, STOP_REQ} = 5'h10 >> k;
    tick();
    {TABLE_CLEAR, DEF_VALID, RUN_REQ, SEQ_PRE_WE, STOP_REQ} = 5'h00;
    tick();
  endtask : strobe

  task pulses(input logic [7:0] k);
    int i;
    n_go = k;
    go = 1'b1;
    for (i = 0; i < 50 && busy !== 1'b1; i++) tick();
    `CHK(busy, 1'b1)
    go = 1'b0;
    for (i = 0; i < 5000 && busy !== 1'b0; i++) tick();
    `CHK(busy, 1'b0)
    tick();
  endtask : pulses

  task load(input count_t v, input logic rej, input logic [4:0] used);
    PRESET_VALUE = v;
    PRESET_VALID = 1'b1;
    tick();
    PRESET_VALID = 1'b0;
    `CHK(PRESET_REJECT, rej)
    `CHK(TABLE_USED, used)
    tick();
  endtask : load

  task rung(input addr_t a, input logic d, input logic rs, input logic rm, input logic ip);
    RUNG_ADDR = a;
    RUNG_IS_DEF = d;
    RUNG_STEP = 1'b1;
    tick();
    RUNG_STEP = 1'b0;
    `CHK(RESTART, rs)
    `CHK(RESUME, rm)
    `CHK(OUT_COMMIT, rm)
    `CHK(INTR_PASS, ip)
    tick();
  endtask : rung

  task wrap_up();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_load();
    int i;
    load(14'h2710, 1'b1, 5'h00);
    `CHK(ERR_CODE, ERR_PRESET_RANGE)
    strobe(0);
    `CHK(ERR_CODE, ERR_NONE)
    DEF_REF = 10'h026F;
    strobe(1);
    `CHK(HSC_DEFINED, 1'b0)
    DEF_REF = HSC_REF_ID;
    strobe(1);
    `CHK(HSC_DEFINED, 1'b1)
    // descending order so the table must sort; no 0 or 1, spaced by four
    load(COUNT_MAX, 1'b0, 5'h01);
    for (i = 19; i > 0; i--) load(14'(i * 4), 1'b0, 5'(21 - i));
    load(14'h0064, 1'b1, TABLE_FULL_USED);
    `CHK(ERR_CODE, ERR_TABLE_FULL)
    strobe(2);
    `CHK(RUN_MODE, 1'b1)
    $display("test load done");
  endtask : t_load

  task t_count();
    pulses(8'h02);
    `CHK(HSC_COUNT, 14'h0000)
    COUNT_ENABLE = 1'b1;
    pulses(8'h03);
    `CHK(HSC_COUNT, 14'h0003)
    $display("test count done");
  endtask : t_count

  task t_intr();
    rung(11'h010, 1'b0, 1'b0, 1'b0, 1'b0);
    pulses(8'h01);
    rung(11'h027, 1'b0, 1'b1, 1'b0, 1'b1);
    rung(11'h001, 1'b0, 1'b0, 1'b0, 1'b1);
    rung(11'h015, 1'b1, 1'b0, 1'b1, 1'b0);
    `CHK(RESUME_ADDR, 11'h027)
    rung(11'h027, 1'b0, 1'b0, 1'b0, 1'b0);
    pulses(8'h48);
    `CHK(HSC_COUNT, 14'h004C)
    rung(11'h033, 1'b0, 1'b1, 1'b0, 1'b1);
    `CHK(RESUME_ADDR, 11'h033)
    strobe(4);
    `CHK(RUN_MODE, 1'b0)
    `CHK(INTR_PASS, 1'b0)
    strobe(2);
    load(14'h0064, 1'b0, TABLE_FULL_USED);
    `CHK(ERR_CODE, ERR_TABLE_FULL)
    $display("test interrupt done");
  endtask : t_intr

  task t_clear();
    CLEAR_COND = 1'b1;
    pulses(8'h02);
    `CHK(HSC_COUNT, 14'h0000)
    CLEAR_COND = 1'b0;
    pulses(8'h02);
    `CHK(HSC_COUNT, 14'h0002)
    clr_req = 1'b1;
    repeat (8) tick();
    clr_req = 1'b0;
    `CHK(HSC_COUNT, 14'h0000)
    $display("test clear done");
  endtask : t_clear

  task t_seq();
    SEQ_PRE_VAL = 10'h002;
    strobe(3);
    repeat (3) begin
      SEQ_STEP_COND[0] = 1'b1;
      tick();
      SEQ_STEP_COND[0] = 1'b0;
      tick();
    end
    SEQ_CMP = 10'h002;
    tick();
    `CHK(SEQ_POS, 10'h002)
    `CHK(SEQ_MATCH, 1'b1)
    SEQ_CLEAR_COND[0] = 1'b1;
    SEQ_STEP_COND[0] = 1'b1;
    repeat (2) tick();
    `CHK(SEQ_POS, SEQ_STEP_HOME)
    SEQ_CLEAR_COND[0] = 1'b0;
    SEQ_STEP_COND[0] = 1'b0;
    tick();
    SEQ_STEP_COND[0] = 1'b1;
    tick();
    SEQ_STEP_COND[0] = 1'b0;
    tick();
    `CHK(SEQ_POS, 10'h001)
    `CHK(SEQ_MATCH, 1'b0)
    SEQ_SEL = 5'h14;
    tick();
    `CHK(SEQ_POS, 10'h000)
    $display("test sequencer done");
  endtask : t_seq

  initial begin
    {COUNT_ENABLE, CLEAR_COND, DEF_VALID, PRESET_VALID, TABLE_CLEAR, RUN_REQ} = '0;
    {STOP_REQ, RUNG_STEP, RUNG_IS_DEF, SEQ_PRE_WE, go, clr_req} = '0;
    {DEF_REF, n_go, SEQ_PRE_IDX, SEQ_SEL, PRESET_VALUE, RUNG_ADDR} = '0;
    {SEQ_PRE_VAL, SEQ_CMP, SEQ_STEP_COND, SEQ_CLEAR_COND} = '0;
    repeat (16) @(posedge CORE_CLK);
    tick();
    NRST = 1'b1;
    tick();
    t_load();
    t_count();
    t_intr();
    t_clear();
    t_seq();
    wrap_up();
  end

  // whole run is just over a thousand cycles
  initial begin
    repeat (30000) @(posedge CORE_CLK);
    n_errors++;
    wrap_up();
  end
endmodule : hsc_core_tb

`default_nettype wire
